// ---- logic/umfic_defs.vh ----
`ifndef UMFIC_DEFS_VH
`define UMFIC_DEFS_VH

// Byte addresses of the register words
`define UMFIC_OFS_HCTRL 5'h00
`define UMFIC_OFS_HSTAT 5'h04
`define UMFIC_OFS_FCTRL 5'h08
`define UMFIC_OFS_IID 5'h0C
`define UMFIC_OFS_IEN 5'h10

// Handshake control fields
`define UMFIC_HC_DTR 0
`define UMFIC_HC_RTS 1
`define UMFIC_HC_LRI 2
`define UMFIC_HC_IRQEN 3
`define UMFIC_HC_LOOP 4

// Handshake status change flags
`define UMFIC_HS_CTSCHG 0
`define UMFIC_HS_DSRCHG 1
`define UMFIC_HS_RIEDGE 2
`define UMFIC_HS_DCDCHG 3

// FIFO control fields
`define UMFIC_FC_EN 0
`define UMFIC_FC_RXRST 1
`define UMFIC_FC_TXRST 2
`define UMFIC_FC_DMA 3
`define UMFIC_FC_TRIG_LO 6
`define UMFIC_FC_TRIG_HI 7

// Interrupt enable fields
`define UMFIC_IE_RX 0
`define UMFIC_IE_TX 1
`define UMFIC_IE_LINE 2
`define UMFIC_IE_MODEM 3

// Receive trigger levels in bytes
`define UMFIC_TRIG_0 5'h01
`define UMFIC_TRIG_1 5'h04
`define UMFIC_TRIG_2 5'h08
`define UMFIC_TRIG_3 5'h0E

// Interrupt identification codes, bits 3:0
`define UMFIC_ID_NONE 4'h1
`define UMFIC_ID_LINE 4'h6
`define UMFIC_ID_RX 4'h4
`define UMFIC_ID_TMO 4'hC
`define UMFIC_ID_TX 4'h2
`define UMFIC_ID_MODEM 4'h0

// Reset values
`define UMFIC_RST_HCTRL 5'h00
`define UMFIC_RST_IEN 4'h0
`define UMFIC_RST_TRIG 2'h0

`endif

// ---- logic/umfic_ctrl.v ----
`timescale 1ns/1ps
`include "umfic_defs.vh"

// How it works
// - Loopback bit 4 forces serial output high and feeds receiver from transmitter.
// - Loopback holds all modem control output pins inactive.
// - Loopback feeds modem inputs from control bits 0,1,2,3 instead of pins.
// - Control bit 3 gates the interrupt output; in loopback it is carrier detect.
// - RTS pin is inverse of control bit 1, DTR pin inverse of bit 0.
// - Status bits 7..4 show carrier, ring, set-ready, clear-to-send as active values.
// - Carrier, set-ready and clear-to-send changes set sticky flags until status read.
// - Ring pin rising low to high sets the ring edge flag until status read.
// - Bits 7:6 pick trigger 1,4,8,14; receive interrupt when count exceeds it.
// - Bit 3 with FIFO mode switches DMA signalling to mode 1.
// - Writing bit 2 pulses a transmit FIFO counter reset; bit self-clears.
// - Writing bit 1 pulses a receive FIFO counter reset; bit self-clears.
// - Bit 0 enables FIFO mode, else single character buffer mode.
// - Identification bits 7,6 read FIFO enable; bits 5,4 read zero.
// - Identification bit 0 is one when idle; bits 3:1 give top source.
// - Line errors rank first, code 0110, cleared by reading line status.
// - Receive ready or trigger ranks second, below timeout, code 0100, cleared by draining.
// - FIFO timeout ranks second, code 1100; bit 3 zero outside FIFO mode.
// - Transmit empty ranks third, code 0010, cleared by write or identification read.
// - Modem change flags rank fourth, code 0000, cleared by status read.
// - Enable bits 3..0 gate modem, line, transmit, receive; bits 7..4 read zero.
module umfic_ctrl #(
    parameter CNT_W = 5
) (
    input wire sys_clk,
    input wire rst,
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire serialInPin,
    output reg serialOutPin,
    input wire txShiftOut,
    output reg rxSerialData,
    input wire ctsPinN,
    input wire dsrPinN,
    input wire riPinN,
    input wire dcdPinN,
    output reg rtsPinN,
    output reg dtrPinN,
    input wire [CNT_W-1:0] rxCount,
    input wire rxDataReady,
    input wire lineErrorActive,
    input wire rxTimeoutActive,
    input wire txBufEmpty,
    output reg fifoEnable,
    output reg dmaMode1,
    output reg txFifoReset,
    output reg rxFifoReset,
    output reg uartIrq
);

    reg [4:0] hctrl_reg;
    reg [3:0] ien_reg;
    reg fifoEn_reg;
    reg dmaSel_reg;
    reg [1:0] trig_reg;
    reg [3:0] chgFlags_reg;
    reg [3:0] prevIn_reg;
    reg prevRiPin_reg;
    reg txPend_reg;
    reg prevTxEmpty_reg;
    reg [4:0] pinSync1_reg;
    reg [4:0] pinSync2_reg;

    wire loopOn;
    wire ctsIn;
    wire dsrIn;
    wire riIn;
    wire dcdIn;
    wire riPinLevel;
    wire [3:0] modemIn;
    wire reqNew;
    wire rdNew;
    wire wrDo;
    wire rxAbove;
    wire srcLine;
    wire srcRx;
    wire srcTmo;
    wire srcTx;
    wire srcModem;
    wire [3:0] idCode;
    wire [7:0] iidByte;
    wire [7:0] hstatByte;
    reg [31:0] readMux;
    wire selHctrl;
    wire selHstat;
    wire selFctrl;
    wire selIid;
    wire selIen;
    wire wrHctrl;
    wire wrFctrl;
    wire wrIen;
    wire rdHstat;
    wire rdIid;
    reg [3:0] chgFlags_next;
    reg txPend_next;

    function [CNT_W-1:0] trigDepth;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: trigDepth = `UMFIC_TRIG_0;
                2'h1: trigDepth = `UMFIC_TRIG_1;
                2'h2: trigDepth = `UMFIC_TRIG_2;
                default: trigDepth = `UMFIC_TRIG_3;
            endcase
        end
    endfunction

    function [3:0] topSource;
        input line;
        input rx;
        input tmo;
        input tx;
        input modem;
        begin
            if (line) begin
                topSource = `UMFIC_ID_LINE;
            end else if (tmo) begin
                topSource = `UMFIC_ID_TMO;
            end else if (rx) begin
                topSource = `UMFIC_ID_RX;
            end else if (tx) begin
                topSource = `UMFIC_ID_TX;
            end else if (modem) begin
                topSource = `UMFIC_ID_MODEM;
            end else begin
                topSource = `UMFIC_ID_NONE;
            end
        end
    endfunction

    function hitReg;
        input [4:0] addr;
        input [4:0] ofs;
        begin
            hitReg = (addr == ofs);
        end
    endfunction

    // Loopback takes the control bit; pins are active low
    function loopSel;
        input loop;
        input ctrlBit;
        input pinN;
        begin
            loopSel = loop ? ctrlBit : ~pinN;
        end
    endfunction

    function levelMoved;
        input nowLevel;
        input oldLevel;
        begin
            levelMoved = nowLevel != oldLevel;
        end
    endfunction

    // Pins come from outside the clock domain
    always @(posedge sys_clk) begin
        if (rst) begin
            pinSync1_reg <= 5'h1F;
            pinSync2_reg <= 5'h1F;
        end else begin
            pinSync1_reg <= {serialInPin, dcdPinN, riPinN, dsrPinN, ctsPinN};
            pinSync2_reg <= pinSync1_reg;
        end
    end

    assign loopOn = hctrl_reg[`UMFIC_HC_LOOP];
    assign ctsIn = loopSel(loopOn, hctrl_reg[`UMFIC_HC_RTS], pinSync2_reg[0]);
    assign dsrIn = loopSel(loopOn, hctrl_reg[`UMFIC_HC_DTR], pinSync2_reg[1]);
    assign riIn = loopSel(loopOn, hctrl_reg[`UMFIC_HC_LRI], pinSync2_reg[2]);
    assign dcdIn = loopSel(loopOn, hctrl_reg[`UMFIC_HC_IRQEN], pinSync2_reg[3]);
    assign riPinLevel = ~riIn;
    assign modemIn = {dcdIn, riIn, dsrIn, ctsIn};
    assign hstatByte = {modemIn, chgFlags_reg};

    // One wait state: the first edge of a request answers, the next one completes it
    assign reqNew = (read | write) & waitrequest;
    assign rdNew = read & waitrequest;
    assign wrDo = write & ~waitrequest & byteenable[0];

    assign selHctrl = hitReg(address, `UMFIC_OFS_HCTRL);
    assign selHstat = hitReg(address, `UMFIC_OFS_HSTAT);
    assign selFctrl = hitReg(address, `UMFIC_OFS_FCTRL);
    assign selIid = hitReg(address, `UMFIC_OFS_IID);
    assign selIen = hitReg(address, `UMFIC_OFS_IEN);
    assign wrHctrl = wrDo & selHctrl;
    assign wrFctrl = wrDo & selFctrl;
    assign wrIen = wrDo & selIen;
    // Read side effects act on the taking edge, together with the snapshot
    assign rdHstat = rdNew & selHstat;
    assign rdIid = rdNew & selIid;

    assign rxAbove = rxCount > trigDepth(trig_reg);
    assign srcLine = ien_reg[`UMFIC_IE_LINE] & lineErrorActive;
    assign srcRx = ien_reg[`UMFIC_IE_RX] & (fifoEn_reg ? rxAbove : rxDataReady);
    assign srcTmo = ien_reg[`UMFIC_IE_RX] & fifoEn_reg & rxTimeoutActive;
    assign srcTx = ien_reg[`UMFIC_IE_TX] & txPend_reg;
    assign srcModem = ien_reg[`UMFIC_IE_MODEM] & (|chgFlags_reg);
    assign idCode = topSource(srcLine, srcRx, srcTmo, srcTx, srcModem);
    assign iidByte = {fifoEn_reg, fifoEn_reg, 2'h0, idCode};

    always @* begin
        readMux = 32'h00000000;
        case (address)
            `UMFIC_OFS_HCTRL: readMux[4:0] = hctrl_reg;
            `UMFIC_OFS_HSTAT: readMux[7:0] = hstatByte;
            `UMFIC_OFS_IID: readMux[7:0] = iidByte;
            `UMFIC_OFS_IEN: readMux[3:0] = ien_reg;
            default: readMux = 32'h00000000;
        endcase
    end

    // Bus slave
    always @(posedge sys_clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~reqNew;
        end
    end

    // Snapshot on the taking edge so a read that clears flags still returns them
    always @(posedge sys_clk) begin
        if (rst) begin
            readdata <= 32'h00000000;
        end else if (rdNew) begin
            readdata <= readMux;
        end
    end

    // Software registers
    always @(posedge sys_clk) begin
        if (rst) begin
            hctrl_reg <= `UMFIC_RST_HCTRL;
        end else if (wrHctrl) begin
            hctrl_reg <= writedata[4:0];
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            ien_reg <= `UMFIC_RST_IEN;
        end else if (wrIen) begin
            ien_reg <= writedata[3:0];
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            fifoEn_reg <= 1'b0;
            dmaSel_reg <= 1'b0;
            trig_reg <= `UMFIC_RST_TRIG;
            txFifoReset <= 1'b0;
            rxFifoReset <= 1'b0;
        end else begin
            txFifoReset <= 1'b0;
            rxFifoReset <= 1'b0;
            if (wrFctrl) begin
                // Other bits still apply if bit 0 is clear; software orders its writes
                fifoEn_reg <= writedata[`UMFIC_FC_EN];
                dmaSel_reg <= writedata[`UMFIC_FC_DMA];
                trig_reg <= writedata[`UMFIC_FC_TRIG_HI:`UMFIC_FC_TRIG_LO];
                txFifoReset <= writedata[`UMFIC_FC_TXRST];
                rxFifoReset <= writedata[`UMFIC_FC_RXRST];
            end
        end
    end

    // Input history for the change detectors
    always @(posedge sys_clk) begin
        if (rst) begin
            prevIn_reg <= 4'h0;
            prevRiPin_reg <= 1'b1;
        end else begin
            prevIn_reg <= modemIn;
            prevRiPin_reg <= riPinLevel;
        end
    end

    // Modem change flags; a change in the read cycle survives the clear
    always @* begin
        chgFlags_next = chgFlags_reg;
        if (rdHstat) begin
            chgFlags_next = 4'h0;
        end
        if (levelMoved(dcdIn, prevIn_reg[3])) begin
            chgFlags_next[`UMFIC_HS_DCDCHG] = 1'b1;
        end
        if (riPinLevel && !prevRiPin_reg) begin
            chgFlags_next[`UMFIC_HS_RIEDGE] = 1'b1;
        end
        if (levelMoved(dsrIn, prevIn_reg[1])) begin
            chgFlags_next[`UMFIC_HS_DSRCHG] = 1'b1;
        end
        if (levelMoved(ctsIn, prevIn_reg[0])) begin
            chgFlags_next[`UMFIC_HS_CTSCHG] = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            chgFlags_reg <= 4'h0;
        end else begin
            chgFlags_reg <= chgFlags_next;
        end
    end

    // Transmit empty event: a fresh empty edge outranks the clear
    always @* begin
        txPend_next = txPend_reg;
        if (txBufEmpty && !prevTxEmpty_reg) begin
            txPend_next = 1'b1;
        end else if (!txBufEmpty) begin
            txPend_next = 1'b0;
        end else if (rdIid && idCode == `UMFIC_ID_TX) begin
            txPend_next = 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            txPend_reg <= 1'b0;
            prevTxEmpty_reg <= 1'b0;
        end else begin
            txPend_reg <= txPend_next;
            prevTxEmpty_reg <= txBufEmpty;
        end
    end

    // Serial path, all registered
    always @(posedge sys_clk) begin
        if (rst) begin
            serialOutPin <= 1'b1;
            rxSerialData <= 1'b1;
        end else begin
            serialOutPin <= loopOn | txShiftOut;
            rxSerialData <= loopOn ? txShiftOut : pinSync2_reg[4];
        end
    end

    // Modem control pins idle high, their inactive level
    always @(posedge sys_clk) begin
        if (rst) begin
            rtsPinN <= 1'b1;
            dtrPinN <= 1'b1;
        end else begin
            rtsPinN <= loopOn | ~hctrl_reg[`UMFIC_HC_RTS];
            dtrPinN <= loopOn | ~hctrl_reg[`UMFIC_HC_DTR];
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            fifoEnable <= 1'b0;
            dmaMode1 <= 1'b0;
        end else begin
            fifoEnable <= fifoEn_reg;
            dmaMode1 <= fifoEn_reg & dmaSel_reg;
        end
    end

    // Interrupt lags its source by one edge but never glitches at the pin
    always @(posedge sys_clk) begin
        if (rst) begin
            uartIrq <= 1'b0;
        end else begin
            uartIrq <= hctrl_reg[`UMFIC_HC_IRQEN] & ~idCode[0];
        end
    end

endmodule // umfic_ctrl

// ---- testbench/umfic_ctrl_properties.sv ----
`timescale 1ns/1ps
`include "umfic_defs.vh"
module umfic_ctrl_properties #(
    parameter CNT_W = 5
) (
    input wire sys_clk,
    input wire rst,
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire serialOutPin,
    input wire txShiftOut,
    input wire rxSerialData,
    input wire rtsPinN,
    input wire dtrPinN,
    input wire fifoEnable,
    input wire dmaMode1,
    input wire txFifoReset,
    input wire rxFifoReset,
    input wire uartIrq
);
    wire wrDone = write && !waitrequest && byteenable[0];
    wire rdDone = read && !waitrequest;
    wire fcWr = wrDone && address == `UMFIC_OFS_FCTRL;
    wire rxRstWr = fcWr && writedata[1];
    reg [4:0] hctl_reg;
    reg [3:0] fctl_reg;
    reg [2:0] age_reg;
    // Outputs lag a write by a few cycles, so checks wait until control is settled
    wire settled = age_reg >= 3'h4;
    always @(posedge sys_clk) begin
        if (rst) begin
            hctl_reg <= 5'h00;
            fctl_reg <= 4'h0;
            age_reg <= 3'h0;
        end else begin
            if (wrDone && address == `UMFIC_OFS_HCTRL)
                hctl_reg <= writedata[4:0];
            if (fcWr)
                fctl_reg <= writedata[3:0];
            if (fcWr || (wrDone && address == `UMFIC_OFS_HCTRL))
                age_reg <= 3'h0;
            else if (age_reg != 3'h7)
                age_reg <= age_reg + 3'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_rts_dtr_level: assert property (
        settled |-> rtsPinN == (hctl_reg[4] | ~hctl_reg[1])
            && dtrPinN == (hctl_reg[4] | ~hctl_reg[0]))
        else $error("modem outputs wrong");
    chk_loop_serial: assert property (
        settled && hctl_reg[4] |-> serialOutPin && rxSerialData == $past(txShiftOut))
        else $error("loopback serial path wrong");
    chk_normal_serial: assert property (
        settled && !hctl_reg[4] |-> serialOutPin == $past(txShiftOut))
        else $error("serial output wrong");
    chk_irq_gate: assert property (
        settled && !hctl_reg[3] |-> !uartIrq)
        else $error("interrupt not gated");
    chk_fifo_mode: assert property (
        settled |-> fifoEnable == fctl_reg[0] && dmaMode1 == (fctl_reg[0] & fctl_reg[3]))
        else $error("fifo mode outputs wrong");
    chk_tx_reset: assert property (
        fcWr && writedata[2] |=> txFifoReset ##1 !txFifoReset)
        else $error("transmit reset pulse wrong");
    chk_rx_reset: assert property (
        $rose(rxFifoReset) |-> $past(rxRstWr) ##1 !rxFifoReset)
        else $error("receive reset pulse wrong");
    chk_rx_reset_fire: assert property (
        rxRstWr |=> rxFifoReset)
        else $error("receive reset pulse missing");
    chk_iid_fixed: assert property (
        rdDone && address == `UMFIC_OFS_IID
        |-> readdata[5:4] == 2'b00 && readdata[7:6] == {2{fctl_reg[0]}})
        else $error("identification upper bits wrong");
    chk_ien_upper: assert property (
        rdDone && address == `UMFIC_OFS_IEN |-> readdata[31:4] == 28'h0)
        else $error("enable upper bits not zero");
    chk_loop_status: assert property (
        settled && hctl_reg[4] && rdDone && address == `UMFIC_OFS_HSTAT
        |-> readdata[7:4] == {hctl_reg[3], hctl_reg[2], hctl_reg[0], hctl_reg[1]})
        else $error("loopback status wrong");
endmodule // umfic_ctrl_properties

// ---- testbench/umfic_modem_model.sv ----
`timescale 1ns/1ps
module umfic_modem_model #(
    parameter LAG = 2
) (
    input wire sys_clk,
    input wire rtsPinN,
    input wire dtrPinN,
    input wire ringOn,
    input wire carrierOn,
    input wire serialOutPin,
    output reg ctsPinN,
    output reg dsrPinN,
    output reg riPinN,
    output reg dcdPinN,
    output wire serialInPin
);
    reg [7:0] rtsDly = 8'hFF;
    reg [7:0] dtrDly = 8'hFF;
    // Modem echoes the line, so the receive path sees real traffic
    assign serialInPin = serialOutPin;
    initial begin
        {ctsPinN, dsrPinN, riPinN, dcdPinN} = 4'hF;
    end
    // Modem answers requests LAG+2 cycles after the pin moves, never at once
    always @(posedge sys_clk) begin
        rtsDly <= {rtsDly[6:0], rtsPinN};
        dtrDly <= {dtrDly[6:0], dtrPinN};
        ctsPinN <= rtsDly[LAG];
        dsrPinN <= dtrDly[LAG];
        riPinN <= ~ringOn;
        dcdPinN <= ~carrierOn;
    end
endmodule // umfic_modem_model

// ---- testbench/test_uart_modem_fifo_interrupt_ctrl.sv ----
`timescale 1ns/1ps
`include "umfic_defs.vh"
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_uart_modem_fifo_interrupt_ctrl;
    localparam CNT_W = 5;
    reg sys_clk = 0;
    reg rst = 1;
    reg [4:0] address = 0;
    reg read = 0;
    reg write = 0;
    reg [31:0] writedata = 0;
    reg [3:0] byteenable = 4'hF;
    reg txShiftOut = 0;
    reg [4:0] rxCount = 0;
    reg rxDataReady = 0;
    reg lineErrorActive = 0;
    reg rxTimeoutActive = 0;
    reg txBufEmpty = 0;
    reg ringOn = 0;
    reg carrierOn = 0;
    wire [31:0] readdata;
    wire waitrequest, serialInPin, serialOutPin, rxSerialData, rtsPinN, dtrPinN, uartIrq;
    wire ctsPinN, dsrPinN, riPinN, dcdPinN, fifoEnable, dmaMode1, txFifoReset, rxFifoReset;
    integer numErrors = 0;
    integer checksDone = 0;
    integer cycles = 0;
    integer i;
    reg [7:0] d;
    reg [4:0] trig [0:3];
    umfic_ctrl #(.CNT_W(CNT_W)) DUT (
        .sys_clk(sys_clk),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .serialInPin(serialInPin),
        .serialOutPin(serialOutPin),
        .txShiftOut(txShiftOut),
        .rxSerialData(rxSerialData),
        .ctsPinN(ctsPinN),
        .dsrPinN(dsrPinN),
        .riPinN(riPinN),
        .dcdPinN(dcdPinN),
        .rtsPinN(rtsPinN),
        .dtrPinN(dtrPinN),
        .rxCount(rxCount),
        .rxDataReady(rxDataReady),
        .lineErrorActive(lineErrorActive),
        .rxTimeoutActive(rxTimeoutActive),
        .txBufEmpty(txBufEmpty),
        .fifoEnable(fifoEnable),
        .dmaMode1(dmaMode1),
        .txFifoReset(txFifoReset),
        .rxFifoReset(rxFifoReset),
        .uartIrq(uartIrq)
    );
    umfic_modem_model modem (
        .sys_clk(sys_clk),
        .rtsPinN(rtsPinN),
        .dtrPinN(dtrPinN),
        .ringOn(ringOn),
        .carrierOn(carrierOn),
        .serialOutPin(serialOutPin),
        .ctsPinN(ctsPinN),
        .dsrPinN(dsrPinN),
        .riPinN(riPinN),
        .dcdPinN(dcdPinN),
        .serialInPin(serialInPin)
    );
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            numErrors++;
            summarize;
        end
    end
    task summarize;
        begin
            $display("checks %0d errors %0d", checksDone, numErrors);
            if (numErrors == 0 && checksDone > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    task bw(input [4:0] a, input [7:0] v);
        begin
            @(posedge sys_clk);
            write <= 1'b1;
            address <= a;
            writedata <= {24'h0, v};
            do @(posedge sys_clk); while (waitrequest !== 1'b0);
            write <= 1'b0;
        end
    endtask
    task br(input [4:0] a, output [7:0] v);
        begin
            @(posedge sys_clk);
            read <= 1'b1;
            address <= a;
            do @(posedge sys_clk); while (waitrequest !== 1'b0);
            v = readdata[7:0];
            read <= 1'b0;
        end
    endtask
    task rc(input [4:0] a, input [7:0] e);
        begin
            br(a, d);
            `CHK(d, e)
        end
    endtask
    initial begin
        trig[0] = 5'h01;
        trig[1] = 5'h04;
        trig[2] = 5'h08;
        trig[3] = 5'h0E;
        wt(16);
        rst <= 1'b0;
        rc(`UMFIC_OFS_IEN, 8'h00);
        rc(`UMFIC_OFS_IID, 8'h01);
        rc(5'h14, 8'h00);
        bw(`UMFIC_OFS_IEN, 8'hFF);
        rc(`UMFIC_OFS_IEN, 8'h0F);
        bw(`UMFIC_OFS_FCTRL, 8'h01);
        for (i = 0; i < 4; i++) begin
            bw(`UMFIC_OFS_FCTRL, {i[1:0], 6'h07});
            rxCount <= trig[i];
            wt(3);
            rc(`UMFIC_OFS_IID, 8'hC1);
            rxCount <= trig[i] + 5'h01;
            wt(3);
            rc(`UMFIC_OFS_IID, 8'hC4);
        end
        rxCount <= 5'h00;
        lineErrorActive <= 1'b1;
        rxTimeoutActive <= 1'b1;
        wt(3);
        rc(`UMFIC_OFS_IID, 8'hC6);
        lineErrorActive <= 1'b0;
        wt(3);
        rc(`UMFIC_OFS_IID, 8'hCC);
        bw(`UMFIC_OFS_FCTRL, 8'h00);
        br(`UMFIC_OFS_IID, d);
        `CHK(d & 8'hC8, 8'h00)
        rxTimeoutActive <= 1'b0;
        rxDataReady <= 1'b1;
        wt(3);
        rc(`UMFIC_OFS_IID, 8'h04);
        rxDataReady <= 1'b0;
        bw(`UMFIC_OFS_FCTRL, 8'h0F);
        wt(4);
        `CHK({fifoEnable, dmaMode1}, 2'b11)
        bw(`UMFIC_OFS_FCTRL, 8'h08);
        wt(4);
        `CHK({fifoEnable, dmaMode1}, 2'b00)
        txBufEmpty <= 1'b1;
        wt(3);
        rc(`UMFIC_OFS_IID, 8'h02);
        rc(`UMFIC_OFS_IID, 8'h01);
        bw(`UMFIC_OFS_HCTRL, 8'h03);
        wt(12);
        `CHK({rtsPinN, dtrPinN, uartIrq}, 3'b000)
        `CHK({serialOutPin, rxSerialData}, 2'b00)
        rc(`UMFIC_OFS_IID, 8'h00);
        bw(`UMFIC_OFS_HCTRL, 8'h0B);
        wt(4);
        `CHK(uartIrq, 1'b1)
        rc(`UMFIC_OFS_HSTAT, 8'h33);
        rc(`UMFIC_OFS_HSTAT, 8'h30);
        wt(3);
        `CHK(uartIrq, 1'b0)
        ringOn <= 1'b1;
        wt(8);
        rc(`UMFIC_OFS_HSTAT, 8'h70);
        ringOn <= 1'b0;
        wt(8);
        rc(`UMFIC_OFS_HSTAT, 8'h34);
        carrierOn <= 1'b1;
        wt(8);
        rc(`UMFIC_OFS_HSTAT, 8'hB8);
        bw(`UMFIC_OFS_HCTRL, 8'h1D);
        wt(6);
        `CHK({rtsPinN, dtrPinN, serialOutPin}, 3'b111)
        br(`UMFIC_OFS_HSTAT, d);
        `CHK(d[7:4], 4'hE)
        `CHK(rxSerialData, 1'b0)
        txShiftOut <= 1'b1;
        wt(3);
        `CHK(rxSerialData, 1'b1)
        summarize;
    end
endmodule // test_uart_modem_fifo_interrupt_ctrl
bind umfic_ctrl umfic_ctrl_properties #(.CNT_W(CNT_W)) chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .serialOutPin(serialOutPin),
    .txShiftOut(txShiftOut),
    .rxSerialData(rxSerialData),
    .rtsPinN(rtsPinN),
    .dtrPinN(dtrPinN),
    .fifoEnable(fifoEnable),
    .dmaMode1(dmaMode1),
    .txFifoReset(txFifoReset),
    .rxFifoReset(rxFifoReset),
    .uartIrq(uartIrq)
);
